// ---- rhft_dev_model.sv ----
// Behavioural reader front end on the far side of the parallel bus
`timescale 1ns/100ps
module rhft_dev_model import rhft_pkg::*; (
   input wire logic clk_in,
   input wire logic [7:0] io_in,
   input wire logic io_oe_in,
   input wire logic dclk_in,
   output logic [7:0] bus_out,
   output logic irq_out
);
   // ==========================================================
   // State
   logic [7:0] regs [0:31] = '{default: 8'h00};
   logic [7:0] fifo [$];
   logic [7:0] txq [$];
   logic [7:0] cmds [$];
   logic [7:0] word = 8'h00, pend_b = 8'h00, drv = 8'h00, last = 8'h00, v;
   logic [4:0] a;
   logic ck_q = 1'b0, d7_q = 1'b0, rose_lo = 1'b0, act = 1'b0, got_w = 1'b0;
   logic pend = 1'b0, drv_en = 1'b0;
   int nb = 0, n_simple = 0, n_cont = 0;
   wire logic h7 = io_oe_in & io_in[7];
   // Released bus shows the device's read byte, else the inverse of its last level, never a stale copy
   assign bus_out = io_oe_in ? io_in : (drv_en ? drv : ~last);
   assign irq_out = |regs[DEV_CAUSE];
   // Bytes arriving over the air; overflow beyond the buffer is dropped
   task automatic rx_byte(input logic [7:0] b);
      if (fifo.size() < DEV_BUF_BYTES) fifo.push_back(b);
      regs[DEV_CAUSE] = regs[DEV_CAUSE] | 8'h40;
   endtask
   // Failed reception; the flag byte is chosen by the caller
   task automatic rx_fail(input logic [7:0] flag);
      regs[DEV_CAUSE] = regs[DEV_CAUSE] | flag;
   endtask
   // The buffer port does not advance, so one stream can carry many bytes
   function automatic logic [4:0] dev_addr();
      return (word[4:0] + nb >= 31) ? DEV_BUFFER : 5'(word[4:0] + nb);
   endfunction
   // ==========================================================
   // Link decoding
   always @(posedge clk_in) begin
      if (ck_q && dclk_in && h7 && !d7_q) begin
         act = 1'b1;
         got_w = 1'b0;
         pend = 1'b0;
         nb = 0;
      end
      if (d7_q && !h7 && ((ck_q && dclk_in) || (!ck_q && !dclk_in && rose_lo))) begin
         act = 1'b0;
         if (dclk_in) n_simple++;
         else n_cont++;
      end
      // Bytes commit on the falling clock so a stop raised mid-high cancels them
      if (act && dclk_in && !ck_q && io_oe_in) begin
         pend_b = io_in;
         pend = 1'b1;
      end
      if (act && !dclk_in && ck_q) begin
         if (pend && !got_w) begin
            word = pend_b;
            got_w = 1'b1;
            if (word == WORD_BUF_RESET) fifo.delete();
            if (word[BIT_CMD]) cmds.push_back(word);
         end else if (pend && !word[BIT_READ] && (word[BIT_CONT] || nb == 0)) begin
            a = dev_addr();
            nb++;
            if (a == DEV_BUFFER) begin
               regs[DEV_CAUSE] = regs[DEV_CAUSE] | 8'h80;
               txq.push_back(pend_b);
            end else if (a != DEV_FILL) begin
               regs[a] = pend_b;
            end
         end
         pend = 1'b0;
         if (got_w && !word[BIT_CMD] && word[BIT_READ] && !io_oe_in
               && (word[BIT_CONT] || nb == 0)) begin
            a = dev_addr();
            nb++;
            v = regs[a];
            if (a == DEV_FILL) v = 8'(fifo.size());
            if (a == DEV_BUFFER) v = (fifo.size() > 0) ? fifo.pop_front() : ~last;
            if (a == DEV_CAUSE) regs[a] = 8'h00;
            drv <= v;
            drv_en <= 1'b1;
         end
      end
      if (io_oe_in || !act) drv_en <= 1'b0;
      rose_lo = !dclk_in && (rose_lo || (h7 && !d7_q));
      ck_q = dclk_in;
      d7_q = h7;
      last <= bus_out;
   end
endmodule

// ---- rhft_host.sv ----
// Host controller driving the reader front end parallel interface
// Summary of operation
// - Command 0x0F empties the device buffer and clears its count.
// - At most 127 bytes per access sequence; longer frames use refills.
// - Host never supplies more bytes than the programmed transmit length in a 0x3D write sequence.
// - Line seven rising while clock high is start; address word follows.
// - Line seven falling while clock high is the simple stop.
// - Line seven rising then falling while clock low is the continuous stop.
// - Host reads cause, then fill count, then drains that many bytes.
// - Host clears buffer with 0x0F before issuing a transmit command.
// - Transmit length written by continuous write 0x3D from 0x1D, then data.
// - Cause is cleared by reading 0x0C then 0x0D in one continuous read.
// - Host sends soft init 0x03 then idle 0x00 before other traffic.
// - Word bit 7 command, bit 6 read, bit 5 continuous addressing.
`timescale 1ns/100ps
module rhft_host import rhft_pkg::*; #(
   parameter int unsigned MAX_BYTES = DEV_BUF_BYTES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic io_oe_out,
   output logic dclk_out,
   input wire logic irq_in
);
   initial begin
      if (MAX_BYTES < 1 || MAX_BYTES > 127) begin
         $error("MAX_BYTES must lie in 1..127");
      end
   end

   typedef enum logic [3:0] {
      ST_IDLE, ST_S1, ST_S2, ST_S3, ST_WLO, ST_WHI, ST_P1, ST_P2, ST_P3
   } rhft_state_t;

   // ==========================================================
   // Pin synchronisers
   logic [7:0] io_m_q, io_s_q;
   logic irq_m_q, irq_s_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         io_m_q <= 8'h00;
         io_s_q <= 8'h00;
         irq_m_q <= 1'b0;
         irq_s_q <= 1'b0;
      end else begin
         io_m_q <= io_in;
         io_s_q <= io_m_q;
         irq_m_q <= irq_in;
         irq_s_q <= irq_m_q;
      end
   end

   // ==========================================================
   // Link clock divider
   logic [7:0] div_q;
   logic tick;
   assign tick = (div_q == 8'(LINK_HALF_CYC - 1));
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q <= DIV_RESET;
      end else if (tick) begin
         div_q <= DIV_RESET;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // ==========================================================
   // Shared signals
   rhft_state_t st_q;
   logic [31:0] ctrl_q;
   logic req_q, ack_q, pend;
   logic [7:0] cur_word_q, cur_n_q, wi_q, moved_q;
   logic cur_cstop_q, pre_done_q;
   logic [1:0] init_q;
   logic err_q;
   logic [6:0] sw_ptr_q;
   logic [7:0] buf_q [0:127];
   logic [7:0] go_word, go_cnt;
   logic [11:0] tx_len;
   logic go_ok, busy;
   assign pend = req_q ^ ack_q;
   assign busy = pend || (st_q != ST_IDLE) || (init_q != 2'b00);
   assign go_word = pwdata_in[CTRL_WORD_LSB +: 8];
   assign go_cnt = pwdata_in[CTRL_CNT_LSB +: 8];
   // Length bytes staged in the buffer ahead of the data
   assign tx_len = {buf_q[0], buf_q[1][7:4]};
   always_comb begin
      go_ok = !busy && (go_cnt <= 8'(MAX_BYTES));
      if (go_word == WORD_TXLEN_WRITE && go_cnt >= 8'h02) begin
         if (12'(go_cnt - 8'h02) > tx_len) begin
            go_ok = 1'b0;
         end
      end
   end

   // ==========================================================
   // APB slave
   logic apb_hit;
   assign apb_hit = psel_in && penable_in && !pready_out;
   // Effect lands when the access is taken, on the same edge that raises pready
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         ctrl_q <= CTRL_RESET;
         req_q <= 1'b0;
         err_q <= 1'b0;
         sw_ptr_q <= 7'h00;
      end else begin
         pready_out <= apb_hit;
         pslverr_out <= 1'b0;
         if (apb_hit) begin
            prdata_out <= 32'h0000_0000;
            case (paddr_in[7:0])
               REG_CTRL: begin
                  if (pwrite_in) begin
                     ctrl_q <= pwdata_in;
                     sw_ptr_q <= 7'h00;
                     if (pwdata_in[CTRL_GO]) begin
                        if (go_ok) begin
                           req_q <= ~req_q;
                           err_q <= 1'b0;
                        end else begin
                           err_q <= 1'b1;
                        end
                     end
                  end else begin
                     prdata_out <= ctrl_q;
                  end
               end
               REG_STATUS: begin
                  // Device interrupt shown live so software can start servicing
                  prdata_out <= {16'h0000, moved_q, 4'h0, err_q, (init_q == 2'b00),
                                 irq_s_q, busy};
               end
               REG_DATA: begin
                  if (!pwrite_in) begin
                     prdata_out <= {24'h000000, buf_q[sw_ptr_q]};
                  end
                  sw_ptr_q <= sw_ptr_q + 7'h01;
               end
               default: begin
                  pslverr_out <= 1'b1;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Staging buffer; no reset needed, contents are always written first
   logic [6:0] link_idx;
   assign link_idx = 7'(wi_q - 8'h01);
   always_ff @(posedge clk_in) begin
      if (apb_hit && pwrite_in && paddr_in[7:0] == REG_DATA) begin
         buf_q[sw_ptr_q] <= pwdata_in[7:0];
      end
      if (st_q == ST_WHI && tick && wi_q != 8'h00 && cur_word_q[BIT_READ]) begin
         buf_q[link_idx] <= io_s_q;
      end
   end

   // ==========================================================
   // Link sequencer
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= ST_IDLE;
         ack_q <= 1'b0;
         init_q <= 2'b11;
         pre_done_q <= 1'b0;
         cur_word_q <= 8'h00;
         cur_n_q <= 8'h00;
         cur_cstop_q <= 1'b0;
         wi_q <= 8'h00;
         moved_q <= 8'h00;
         io_out <= 8'h00;
         io_oe_out <= 1'b0;
         dclk_out <= 1'b0;
      end else if (tick) begin
         case (st_q)
            ST_IDLE: begin
               dclk_out <= 1'b0;
               io_oe_out <= 1'b0;
               cur_cstop_q <= 1'b0;
               cur_n_q <= 8'h00;
               wi_q <= 8'h00;
               if (init_q != 2'b00) begin
                  // Soft init, then idle, ahead of anything software asks
                  cur_word_q <= init_q[1] ? WORD_SOFT_INIT : WORD_IDLE;
                  init_q <= {1'b0, init_q[1]};
                  st_q <= ST_S1;
               end else if (pend) begin
                  st_q <= ST_S1;
                  if (ctrl_q[CTRL_PRERESET] && !pre_done_q) begin
                     cur_word_q <= WORD_BUF_RESET;
                     pre_done_q <= 1'b1;
                  end else begin
                     pre_done_q <= 1'b0;
                     ack_q <= ~ack_q;
                     cur_word_q <= ctrl_q[CTRL_WORD_LSB +: 8];
                     cur_cstop_q <= ctrl_q[CTRL_CSTOP];
                     if (ctrl_q[CTRL_WORD_LSB + BIT_CMD]) begin
                        cur_n_q <= 8'h00;
                     end else if (!ctrl_q[CTRL_WORD_LSB + BIT_CONT]) begin
                        cur_n_q <= (ctrl_q[CTRL_CNT_LSB +: 8] == 8'h00) ? 8'h00 : 8'h01;
                     end else begin
                        cur_n_q <= ctrl_q[CTRL_CNT_LSB +: 8];
                     end
                  end
               end
            end
            ST_S1: begin
               io_oe_out <= 1'b1;
               io_out <= 8'h00;
               dclk_out <= 1'b1;
               st_q <= ST_S2;
            end
            ST_S2: begin
               io_out[7] <= 1'b1;
               st_q <= ST_S3;
            end
            ST_S3: begin
               dclk_out <= 1'b0;
               io_out <= cur_word_q;
               st_q <= ST_WLO;
            end
            ST_WLO: begin
               dclk_out <= 1'b1;
               st_q <= ST_WHI;
            end
            ST_WHI: begin
               dclk_out <= 1'b0;
               if (wi_q == cur_n_q) begin
                  moved_q <= cur_n_q;
                  io_oe_out <= 1'b1;
                  io_out <= {~cur_cstop_q, 7'h00};
                  st_q <= ST_P1;
               end else begin
                  wi_q <= wi_q + 8'h01;
                  // Bus released while the device answers a read
                  io_oe_out <= !cur_word_q[BIT_READ];
                  io_out <= buf_q[wi_q[6:0]];
                  st_q <= ST_WLO;
               end
            end
            ST_P1: begin
               if (cur_cstop_q) begin
                  io_out[7] <= 1'b1;
               end else begin
                  dclk_out <= 1'b1;
               end
               st_q <= ST_P2;
            end
            ST_P2: begin
               io_out[7] <= 1'b0;
               st_q <= ST_P3;
            end
            ST_P3: begin
               dclk_out <= 1'b0;
               io_oe_out <= 1'b0;
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   a_start_while_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st_q == ST_S3 && $rose(st_q == ST_S3)) |-> io_out[7] && dclk_out && $past(!io_out[7]))
      else $error("start edge not formed with clock high");
   a_simple_stop: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ($rose(st_q == ST_P3) && !cur_cstop_q) |-> dclk_out && !io_out[7] && $past(io_out[7]))
      else $error("simple stop malformed");
   a_cont_stop: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ($rose(st_q == ST_P3) && cur_cstop_q) |-> !dclk_out && !io_out[7]
         && $past(io_out[7]) && $past(!dclk_out))
      else $error("continuous stop malformed");
   a_reset_word: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ($rose(st_q == ST_S1) && pre_done_q && pend) |-> cur_word_q == WORD_BUF_RESET)
      else $error("buffer reset word wrong");
   a_init_first: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ($rose(st_q == ST_S1) && init_q == 2'b01) |-> cur_word_q == WORD_SOFT_INIT)
      else $error("soft init not sent first");
   a_count_limit: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st_q != ST_IDLE) |-> cur_n_q <= 8'(MAX_BYTES))
      else $error("sequence longer than buffer");
   a_len_guard: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st_q == ST_WLO && cur_word_q == WORD_TXLEN_WRITE && cur_n_q >= 8'h02)
         |-> 12'(cur_n_q - 8'h02) <= tx_len)
      else $error("data exceeds transmit length");
   a_read_release: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st_q == ST_WHI && wi_q != 8'h00 && cur_word_q[BIT_READ]) |-> !io_oe_out)
      else $error("bus driven during read data");
   a_single_word: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st_q == ST_WLO && !cur_word_q[BIT_CONT] && !cur_word_q[BIT_CMD]) |-> wi_q <= 8'h01)
      else $error("extra word in single address mode");
   a_apb_answer: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (psel_in && penable_in && !pready_out) |=> pready_out)
      else $error("apb answer late");
   a_cmd_no_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (st_q == ST_WLO && cur_word_q[BIT_CMD]) |-> cur_n_q == 8'h00)
      else $error("data sent after a command word");
   a_stop_release: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $rose(st_q == ST_IDLE) |-> !io_oe_out && !dclk_out)
      else $error("bus or clock left driven after stop");
   c_tx_len_write: cover property (@(posedge clk_in) disable iff (!resetn_in)
      st_q == ST_WLO && cur_word_q == WORD_TXLEN_WRITE && wi_q == 8'h03);
   c_cause_read: cover property (@(posedge clk_in) disable iff (!resetn_in)
      st_q == ST_P1 && cur_word_q == WORD_CAUSE_READ && cur_n_q == 8'h02);
   c_cont_stop: cover property (@(posedge clk_in) disable iff (!resetn_in)
      st_q == ST_P3 && cur_cstop_q);
   c_pre_reset: cover property (@(posedge clk_in) disable iff (!resetn_in)
      st_q == ST_S3 && cur_word_q == WORD_BUF_RESET);
endmodule

// ---- rhft_host_tb.sv ----
// Self-checking bench for the reader host transfer controller
`timescale 1ns/100ps
module rhft_host_tb import rhft_pkg::*; ;
   // ==========================================================
   // Signals and partner
   logic clk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r, x = 32'h24;
   logic pready, pslverr, io_oe, dclk, irq, e;
   logic [7:0] io_out, bus, b;
   logic [7:0] tx [$];
   logic [7:0] exp_q [$];
   int n_errors = 0, cmp_count = 0;
   always #2 clk_in = ~clk_in;
   rhft_host uut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .io_in(bus),
      .io_out(io_out), .io_oe_out(io_oe), .dclk_out(dclk), .irq_in(irq));
   rhft_dev_model dev (.clk_in(clk_in), .io_in(io_out), .io_oe_in(io_oe),
      .dclk_in(dclk), .bus_out(bus), .irq_out(irq));
   // ==========================================================
   // Helpers
   function automatic logic [7:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x[7:0];
   endfunction
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One transfer; the request is held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      k = 0;
      @(posedge clk_in);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge clk_in);
         k++;
      end
      if (pready !== 1'b1) begin
         n_errors++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic poll(input int bit_ix, input logic val);
      int k;
      for (k = 0; k < 3000; k++) begin
         apb(1'b0, REG_STATUS, 32'h0);
         if (r[bit_ix] === val) break;
      end
      if (k == 3000) begin
         n_errors++;
         final_report();
      end
   endtask
   // Flags are {go, pre-reset, continuous stop}; leaves the final status in r
   task automatic run(input logic [7:0] w, input logic [7:0] n, input logic [2:0] f);
      apb(1'b1, REG_CTRL, {13'h0, f, n, w});
      poll(0, 1'b0);
   endtask
   task automatic load();
      apb(1'b1, REG_CTRL, 32'h0);
      foreach (tx[i]) apb(1'b1, REG_DATA, {24'h0, tx[i]});
   endtask
   task automatic rd_byte(input string name, input logic [7:0] exp);
      apb(1'b0, REG_DATA, 32'h0);
      chk(name, r[7:0], exp);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      poll(2, 1'b1);
      // Init done rises as the last init word starts; wait for the link to go idle
      poll(0, 1'b0);
      chk("init_word0", dev.cmds[0], WORD_SOFT_INIT);
      chk("init_word1", dev.cmds[1], WORD_IDLE);
      chk("simple_stops", dev.n_simple, 32'h2);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped_err", e, 1'h1);
      tx = {8'h7c};
      load();
      run(8'h14, 8'h01, 3'h4);
      chk("levels_reg", dev.regs[DEV_LEVELS], 8'h7c);
      run(8'h54, 8'h01, 3'h4);
      rd_byte("levels_read", 8'h7c);
      tx = {8'h00, 8'h50};
      for (int i = 0; i < 5; i++) tx.push_back(rnd());
      load();
      run(WORD_TXLEN_WRITE, 8'h07, 3'h6);
      chk("pre_reset", dev.cmds[2], WORD_BUF_RESET);
      chk("len_high", dev.regs[DEV_TXLEN_HI], 8'h00);
      chk("len_low", dev.regs[DEV_TXLEN_LO], 8'h50);
      for (int i = 0; i < 5; i++) chk("tx_byte", dev.txq[i], tx[i + 2]);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("irq_tx", r[1], 1'h1);
      run(WORD_CAUSE_READ, 8'h02, 3'h4);
      rd_byte("cause_tx", 8'h80);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("irq_clear", r[1], 1'h0);
      dev.rx_fail(8'h10);
      run(WORD_CAUSE_READ, 8'h02, 3'h4);
      rd_byte("cause_err", 8'h10);
      for (int i = 0; i < 127; i++) begin
         b = rnd();
         exp_q.push_back(b);
         dev.rx_byte(b);
      end
      run(WORD_CAUSE_READ, 8'h02, 3'h5);
      rd_byte("cause_rx", 8'h40);
      chk("cont_stop", dev.n_cont, 32'h1);
      run(8'h5c, 8'h01, 3'h4);
      rd_byte("fill_full", 8'h7f);
      run(8'h7f, 8'h7f, 3'h4);
      chk("moved", r[15:8], 8'h7f);
      foreach (exp_q[i]) rd_byte("rx_byte", exp_q[i]);
      run(8'h5c, 8'h01, 3'h4);
      rd_byte("fill_empty", 8'h00);
      run(8'h7f, 8'h80, 3'h4);
      chk("over_max", r[3], 1'h1);
      tx = {8'h00, 8'h10};
      load();
      run(WORD_TXLEN_WRITE, 8'h04, 3'h4);
      chk("over_len", r[3], 1'h1);
      chk("no_tx", dev.txq.size(), 32'h5);
      final_report();
   end
endmodule

// ---- rhft_pkg.sv ----
// Constants for the reader host transfer controller
package rhft_pkg;
   // ==========================================================
   // Address/command word layout
   localparam int unsigned BIT_CMD = 7;
   localparam int unsigned BIT_READ = 6;
   localparam int unsigned BIT_CONT = 5;
   localparam logic [7:0] WORD_SOFT_INIT = 8'h83;
   localparam logic [7:0] WORD_IDLE = 8'h80;
   localparam logic [7:0] WORD_BUF_RESET = 8'h8f;
   localparam logic [7:0] WORD_TXLEN_WRITE = 8'h3d;
   localparam logic [7:0] WORD_CAUSE_READ = 8'h6c;
   // ==========================================================
   // Device register map
   localparam logic [4:0] DEV_CAUSE = 5'h0c;
   localparam logic [4:0] DEV_MASK = 5'h0d;
   localparam logic [4:0] DEV_LEVELS = 5'h14;
   localparam logic [4:0] DEV_FILL = 5'h1c;
   localparam logic [4:0] DEV_TXLEN_HI = 5'h1d;
   localparam logic [4:0] DEV_TXLEN_LO = 5'h1e;
   localparam logic [4:0] DEV_BUFFER = 5'h1f;
   localparam int unsigned DEV_BUF_BYTES = 127;
   // ==========================================================
   // Own APB registers
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam int unsigned CTRL_WORD_LSB = 0;
   localparam int unsigned CTRL_CNT_LSB = 8;
   localparam int unsigned CTRL_CSTOP = 16;
   localparam int unsigned CTRL_PRERESET = 17;
   localparam int unsigned CTRL_GO = 18;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ==========================================================
   // Link timing
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned LINK_HALF_NS = 32;
   localparam int unsigned LINK_HALF_CYC = (LINK_HALF_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [7:0] DIV_RESET = 8'h00;
endpackage
